// [hdl/csb_unit.v]
// Purpose: executes compares, bit skips and relative branches
// Assumes: core hands one decoded operation at a time on the issue port
// Notes:   operand values arrive already read from the register file
//
// The address map and the address-and-strobe port were decided locally.
`include "csb_map.vh"

module csb_unit #(
  parameter PC_W = 16
) (
  input  wire            CLK,
  input  wire            RST,
  input  wire            OP_VALID,
  input  wire [3:0]      OP_CODE,
  input  wire [7:0]      OP_DST,
  input  wire [7:0]      OP_SRC,
  input  wire [2:0]      OP_BIT,
  input  wire [6:0]      OP_OFFSET,
  input  wire            NEXT_TWO_WORD,
  input  wire [3:0]      ADDR,
  input  wire [15:0]     WDATA,
  input  wire            WR,
  input  wire            RD,
  output reg  [15:0]     RDATA,
  output reg  [PC_W-1:0] PC_OUT,
  output reg  [7:0]      FLAGS_OUT,
  output reg             BUSY,
  output reg             DONE,
  output reg             TAKEN
);
  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_STALL = 2'b10;

  reg  [1:0]      state_q;
  reg  [1:0]      state_d;
  reg  [1:0]      wait_q;
  reg  [1:0]      wait_d;
  reg  [PC_W-1:0] pc_q;
  reg  [PC_W-1:0] pc_d;
  reg  [7:0]      flags_q;
  reg  [7:0]      flags_d;
  reg  [15:0]     ctrl_q;
  reg             taken_q;
  reg             taken_d;
  reg  [1:0]      cycles_q;
  reg  [1:0]      cycles_d;
  reg             done_d;

  wire            accept;
  wire [5:0]      cmp_flags;
  wire            is_cmp;
  wire            is_skip;
  wire            is_branch;
  wire            bit_val;
  wire            flag_val;
  reg             cond;
  wire [PC_W-1:0] k_ext;
  wire [PC_W-1:0] pc_next;
  wire [PC_W+15:0] pc_pad;
  wire [PC_W+15:0] skip_pad;
  wire [PC_W-1:0]  skip_dist;

  // Operations are held off while an earlier one still occupies the pipeline
  assign accept    = OP_VALID & state_q[0] & ctrl_q[`CSB_CTRL_EN_BIT];
  assign is_cmp    = (OP_CODE == `CSB_OP_CMP_CARRY) | (OP_CODE == `CSB_OP_CMP_IMM);
  assign is_skip   = (OP_CODE >= `CSB_OP_SKIP_RCLR) & (OP_CODE <= `CSB_OP_SKIP_IOSET);
  assign is_branch = (OP_CODE >= `CSB_OP_BR_FSET) & (OP_CODE <= `CSB_OP_BR_CCLR);
  assign bit_val   = OP_SRC[OP_BIT];
  assign flag_val  = flags_q[OP_BIT];
  assign k_ext     = {{(PC_W-7){OP_OFFSET[6]}}, OP_OFFSET};
  assign pc_next   = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
  // Padded copies make the cut to 16 or PC_W bits explicit for any width
  assign pc_pad    = {16'h0000, pc_q};
  assign skip_pad  = {{PC_W{1'b0}}, (NEXT_TWO_WORD ? `CSB_SKIP_LONG : `CSB_SKIP_SHORT)};
  assign skip_dist = skip_pad[PC_W-1:0];

  csb_cmp u_cmp (
    .a          (OP_DST),
    .b          (OP_SRC),
    .borrow_in  ((OP_CODE == `CSB_OP_CMP_CARRY) & flags_q[`CSB_FLAG_C]),
    .chain_zero (OP_CODE == `CSB_OP_CMP_CARRY),
    .z_in       (flags_q[`CSB_FLAG_Z]),
    .flags      (cmp_flags)
  );

  always @* begin
    case (OP_CODE)
      `CSB_OP_SKIP_RCLR:  cond = ~bit_val;
      `CSB_OP_SKIP_RSET:  cond = bit_val;
      `CSB_OP_SKIP_IOCLR: cond = ~bit_val;
      `CSB_OP_SKIP_IOSET: cond = bit_val;
      `CSB_OP_BR_FSET:    cond = flag_val;
      `CSB_OP_BR_FCLR:    cond = ~flag_val;
      `CSB_OP_BR_EQ:      cond = flags_q[`CSB_FLAG_Z];
      `CSB_OP_BR_NE:      cond = ~flags_q[`CSB_FLAG_Z];
      `CSB_OP_BR_CSET:    cond = flags_q[`CSB_FLAG_C];
      `CSB_OP_BR_CCLR:    cond = ~flags_q[`CSB_FLAG_C];
      default:            cond = 1'b0;
    endcase
  end

  always @* begin
    pc_d     = pc_q;
    flags_d  = flags_q;
    taken_d  = taken_q;
    cycles_d = cycles_q;
    state_d  = state_q;
    wait_d   = wait_q;
    done_d   = 1'b0;
    // Bus writes yield to an operation landing in the same cycle
    if (WR && ADDR == `CSB_REG_FLAGS && !accept) begin
      flags_d = WDATA[7:0];
    end
    if (WR && ADDR == `CSB_REG_PC && !accept) begin
      pc_d = WDATA[PC_W-1:0];
    end
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          taken_d  = is_cmp ? 1'b0 : cond;
          cycles_d = `CSB_CYC_ONE;
          pc_d     = pc_next;
          if (is_cmp) begin
            // Compares store no difference, only the flags
            flags_d[5:0] = cmp_flags;
          end else if (is_skip && cond) begin
            // Skip distance follows the length of the skipped word
            pc_d     = pc_q + skip_dist;
            cycles_d = NEXT_TWO_WORD ? `CSB_CYC_THREE : `CSB_CYC_TWO;
          end else if (is_branch && cond) begin
            pc_d     = pc_next + k_ext;
            cycles_d = `CSB_CYC_TWO;
          end
          if (cycles_d == `CSB_CYC_ONE) begin
            done_d = 1'b1;
          end else begin
            state_d = ST_STALL;
            wait_d  = cycles_d - `CSB_CYC_ONE;
          end
        end
      end
      ST_STALL: begin
        wait_d = wait_q - `CSB_CYC_ONE;
        if (wait_q == `CSB_CYC_ONE) begin
          state_d = ST_IDLE;
          done_d  = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        wait_d  = 2'h0;
      end
    endcase
  end

  always @(posedge CLK) begin
    if (RST) begin
      state_q  <= ST_IDLE;
      wait_q   <= 2'h0;
      pc_q     <= `CSB_PC_RESET;
      flags_q  <= `CSB_FLAGS_RESET;
      taken_q  <= 1'b0;
      cycles_q <= 2'h0;
      ctrl_q   <= `CSB_CTRL_RESET;
    end else begin
      state_q  <= state_d;
      wait_q   <= wait_d;
      pc_q     <= pc_d;
      flags_q  <= flags_d;
      taken_q  <= taken_d;
      cycles_q <= cycles_d;
      if (WR && ADDR == `CSB_REG_CTRL) begin
        ctrl_q <= {15'h0000, WDATA[`CSB_CTRL_EN_BIT]};
      end
    end
  end

  // Outputs other than RDATA mirror the next state so they come straight from flops
  always @(posedge CLK) begin
    if (RST) begin
      PC_OUT    <= `CSB_PC_RESET;
      FLAGS_OUT <= `CSB_FLAGS_RESET;
      BUSY      <= 1'b0;
      DONE      <= 1'b0;
      TAKEN     <= 1'b0;
      RDATA     <= 16'h0000;
    end else begin
      PC_OUT    <= pc_d;
      FLAGS_OUT <= flags_d;
      BUSY      <= state_d[1];
      DONE      <= done_d;
      TAKEN     <= taken_d;
      RDATA     <= 16'h0000;
      if (RD) begin
        case (ADDR)
          `CSB_REG_FLAGS:  RDATA <= {8'h00, flags_q};
          `CSB_REG_PC:     RDATA <= pc_pad[15:0];
          `CSB_REG_STATUS: RDATA <= {12'h000, cycles_q, taken_q, state_q[1]};
          `CSB_REG_CTRL:   RDATA <= ctrl_q;
          default:         RDATA <= 16'h0000;
        endcase
      end
    end
  end
endmodule

// [hdl/csb_map.vh]
// Purpose: constants for the compare, skip and branch execution unit
// Assumes: 16-bit register port, program counter counts words
// Notes:   definitions only
// Contract
// - Compare with carry sets flags, one cycle
// - Compare with immediate sets flags, no store
// - Register bit clear skips by 2/3
// - Register bit set skips by 2/3
// - I/O bit clear skips, flags kept
// - I/O bit set skips, flags kept
// - Flag set branches to PC+k+1
// - Flag clear branches, flags kept
// - Zero set branches, 1 or 2 cycles
// - Zero clear branches, flags kept
// - Carry set branches, else sequential
// - Carry clear branches, no flag change
`ifndef CSB_MAP_VH
`define CSB_MAP_VH

`define CSB_OP_CMP_CARRY   4'h0
`define CSB_OP_CMP_IMM     4'h1
`define CSB_OP_SKIP_RCLR   4'h2
`define CSB_OP_SKIP_RSET   4'h3
`define CSB_OP_SKIP_IOCLR  4'h4
`define CSB_OP_SKIP_IOSET  4'h5
`define CSB_OP_BR_FSET     4'h6
`define CSB_OP_BR_FCLR     4'h7
`define CSB_OP_BR_EQ       4'h8
`define CSB_OP_BR_NE       4'h9
`define CSB_OP_BR_CSET     4'hA
`define CSB_OP_BR_CCLR     4'hB

`define CSB_FLAG_C         3'h0
`define CSB_FLAG_Z         3'h1
`define CSB_FLAG_N         3'h2
`define CSB_FLAG_V         3'h3
`define CSB_FLAG_S         3'h4
`define CSB_FLAG_H         3'h5

`define CSB_REG_FLAGS      4'h0
`define CSB_REG_PC         4'h4
`define CSB_REG_STATUS     4'h8
`define CSB_REG_CTRL       4'hC

`define CSB_FLAGS_RESET    8'h00
`define CSB_PC_RESET       16'h0000
`define CSB_CTRL_RESET     16'h0001
`define CSB_CTRL_EN_BIT    0

`define CSB_CYC_ONE        2'h1
`define CSB_CYC_TWO        2'h2
`define CSB_CYC_THREE      2'h3
`define CSB_SKIP_SHORT     16'h0002
`define CSB_SKIP_LONG      16'h0003

`endif

// [hdl/csb_cmp.v]
// Purpose: subtract-and-discard flag generator for both compares
// Assumes: operands are plain 8-bit values
// Notes:   the difference itself never leaves this module
`include "csb_map.vh"

module csb_cmp (
  input  wire [7:0] a,
  input  wire [7:0] b,
  input  wire       borrow_in,
  input  wire       chain_zero,
  input  wire       z_in,
  output wire [5:0] flags
);
  wire [7:0] r;
  wire       c_out;
  wire       h_out;
  wire       v_out;
  wire       z_out;

  assign r     = a - b - {7'h00, borrow_in};
  assign h_out = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
  assign c_out = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
  assign v_out = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
  // Chained compare keeps zero only if every byte so far was zero
  assign z_out = (r == 8'h00) & (~chain_zero | z_in);
  assign flags = {h_out, r[7] ^ v_out, v_out, r[7], z_out, c_out};
endmodule

// [verification/csb_unit_monitor.sv]
// Purpose: port timing checks for the compare, skip and branch unit
// Assumes: no bus write beside an issue
// Notes:   issue taken when valid, idle and enabled
module csb_monitor #(
  parameter PC_W = 16
) (
  input wire            CLK,
  input wire            RST,
  input wire            OP_VALID,
  input wire [3:0]      OP_CODE,
  input wire [6:0]      OP_OFFSET,
  input wire            NEXT_TWO_WORD,
  input wire            WR,
  input wire [3:0]      ADDR,
  input wire [15:0]     WDATA,
  input wire [PC_W-1:0] PC_OUT,
  input wire [7:0]      FLAGS_OUT,
  input wire            BUSY,
  input wire            DONE,
  input wire            TAKEN
);
  timeunit 1ns;
  timeprecision 100ps;
  // Shadow of the enable bit, so refused issues are not checked as accepted
  logic en_q;
  always @(posedge CLK) begin
    if (RST) begin
      en_q <= 1'b1;
    end else if (WR && ADDR == 4'hC) begin
      en_q <= WDATA[0];
    end
  end
  wire acc = OP_VALID && !BUSY && !WR && en_q;
  wire skp = acc && OP_CODE >= 4'h2 && OP_CODE <= 4'h5;
  wire brn = acc && OP_CODE >= 4'h6 && OP_CODE <= 4'hB;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  cmp_one_cycle_a: assert property (acc && OP_CODE < 4'h2 |=> DONE && !BUSY && !TAKEN
    && FLAGS_OUT[4] == (FLAGS_OUT[2] ^ FLAGS_OUT[3]) && PC_OUT == PC_W'($past(PC_OUT) + 1'b1))
    else $error("compare not one cycle");
  flags_kept_a: assert property (skp || brn |=> $stable(FLAGS_OUT))
    else $error("flags changed by skip or branch");
  skip_dist_a: assert property (skp ##1 TAKEN |->
    PC_OUT == PC_W'($past(PC_OUT) + ($past(NEXT_TWO_WORD) ? 2'h3 : 2'h2))) else $error("skip distance wrong");
  skip_long_a: assert property ((skp && NEXT_TWO_WORD) ##1 TAKEN |-> BUSY ##1 BUSY ##1 (DONE && !BUSY))
    else $error("long skip not three cycles");
  skip_short_a: assert property ((skp && !NEXT_TWO_WORD) ##1 TAKEN |-> BUSY ##1 (DONE && !BUSY))
    else $error("short skip not two cycles");
  skip_fall_a: assert property (skp ##1 !TAKEN |-> DONE && !BUSY)
    else $error("untaken skip not one cycle");
  branch_dest_a: assert property (brn |=> PC_OUT == PC_W'($past(PC_OUT) + 1'b1
    + (TAKEN ? {{(PC_W-7){$past(OP_OFFSET[6])}}, $past(OP_OFFSET)} : 1'b0))) else $error("branch target wrong");
  branch_time_a: assert property (brn ##1 TAKEN |-> BUSY ##1 (DONE && !BUSY))
    else $error("taken branch not two cycles");
  branch_fall_a: assert property (brn ##1 !TAKEN |-> DONE && !BUSY)
    else $error("untaken branch not one cycle");
  stall_hold_a: assert property (BUSY && !WR |=> $stable(PC_OUT) && $stable(FLAGS_OUT))
    else $error("state moved during stall");
endmodule

// [verification/csb_unit_test.sv]
// Purpose: random and corner tests of the compare, skip and branch unit
// Assumes: no bus write beside an issue
// Notes:   expectations come from model below
`include "csb_map.vh"
module csb_unit_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        CLK = 0, RST = 1, OP_VALID = 0, NEXT_TWO_WORD = 0, WR = 0, RD = 0;
  logic [3:0]  OP_CODE = 0, ADDR = 0;
  logic [7:0]  OP_DST = 0, OP_SRC = 0, e_fl = 0;
  logic [2:0]  OP_BIT = 0;
  logic [6:0]  OP_OFFSET = 0;
  logic [15:0] WDATA = 0, e_pc = 0;
  logic [1:0]  e_cy = 1;
  logic        e_tk = 0;
  logic [31:0] r;
  wire  [15:0] RDATA, PC_OUT;
  wire  [7:0]  FLAGS_OUT;
  wire         BUSY, DONE, TAKEN;
  int          failures = 0, checks_done = 0, cyc = 0, seed;
  csb_unit #(.PC_W(16)) csb_unit_inst (.CLK, .RST, .OP_VALID, .OP_CODE, .OP_DST, .OP_SRC, .OP_BIT, .OP_OFFSET,
    .NEXT_TWO_WORD, .ADDR, .WDATA, .WR, .RD, .RDATA, .PC_OUT, .FLAGS_OUT, .BUSY, .DONE, .TAKEN);
  initial forever #10 CLK = ~CLK;
  task conclude;
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("Error %0t got %h exp %h", $time, got, exp);
      failures++;
    end
  endtask
  function automatic void model(input [3:0] c, input [7:0] d, input [7:0] s, input [2:0] b, input [6:0] k, input t);
    logic [8:0] x;
    logic       q;
    q = 0;
    e_cy = 1;
    x = {1'b0, d} - {1'b0, s} - (c == 0 ? e_fl[0] : 1'b0);
    case (c)
      4'h0, 4'h1: begin
        // Carry form keeps Z so multi-byte compares chain
        e_fl[1] = (x[7:0] == 0) && (c == 1 || e_fl[1]);
        e_fl[0] = x[8];
        e_fl[2] = x[7];
        e_fl[3] = (d[7] & ~s[7] & ~x[7]) | (~d[7] & s[7] & x[7]);
        e_fl[4] = e_fl[2] ^ e_fl[3];
        e_fl[5] = (~d[3] & s[3]) | (s[3] & x[3]) | (x[3] & ~d[3]);
      end
      4'h2, 4'h4: q = !s[b];
      4'h3, 4'h5: q = s[b];
      4'h6: q = e_fl[b];
      4'h7: q = !e_fl[b];
      4'h8: q = e_fl[1];
      4'h9: q = !e_fl[1];
      4'hA: q = e_fl[0];
      4'hB: q = !e_fl[0];
      default: q = 0;
    endcase
    e_tk = q;
    e_cy = !q ? 2'h1 : c > 5 ? 2'h2 : t ? 2'h3 : 2'h2;
    e_pc = e_pc + (!q ? 16'h1 : c > 5 ? 16'h1 + {{9{k[6]}}, k} : {14'h0, e_cy});
  endfunction
  task op(input [3:0] c, input [7:0] d, input [7:0] s, input [2:0] b, input [6:0] k, input t);
    int n;
    model(c, d, s, b, k, t);
    @(posedge CLK);
    OP_VALID <= 1;
    OP_CODE <= c;
    OP_DST <= d;
    OP_SRC <= s;
    OP_BIT <= b;
    OP_OFFSET <= k;
    NEXT_TWO_WORD <= t;
    @(posedge CLK);
    OP_VALID <= 0;
    #1;
    n = 1;
    while (DONE !== 1'b1 && n < 4) begin
      @(posedge CLK);
      #1;
      n++;
    end
    chk(n, e_cy);
    chk(PC_OUT, e_pc);
    chk(FLAGS_OUT, e_fl);
    chk(TAKEN, e_tk);
  endtask
  task rd(input [3:0] a, input [15:0] e);
    @(posedge CLK);
    RD <= 1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 0;
    #1;
    chk(RDATA, e);
  endtask
  task wr(input [3:0] a, input [15:0] v);
    @(posedge CLK);
    WR <= 1;
    ADDR <= a;
    WDATA <= v;
    @(posedge CLK);
    WR <= 0;
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      conclude;
    end
  end
  initial begin
    repeat (20) @(posedge CLK);
    RST <= 0;
    seed = $urandom(85393);
    wr(`CSB_REG_FLAGS, 16'h0003);
    e_fl = 8'h03;
    op(`CSB_OP_CMP_CARRY, 8'h05, 8'h04, 0, 0, 0);
    op(`CSB_OP_BR_EQ, 0, 0, 0, 7'h40, 0);
    op(`CSB_OP_SKIP_IOCLR, 0, 8'hFE, 0, 0, 1);
    op(`CSB_OP_SKIP_RSET, 0, 8'h80, 7, 0, 0);
    wr(4'h2, 16'hFFFF);
    rd(4'h2, 16'h0000);
    rd(`CSB_REG_FLAGS, {8'h00, e_fl});
    rd(`CSB_REG_STATUS, {12'h000, e_cy, e_tk, 1'b0});
    // Issue while disabled must be ignored
    wr(`CSB_REG_CTRL, 16'h0000);
    @(posedge CLK);
    OP_VALID <= 1;
    OP_CODE <= `CSB_OP_CMP_IMM;
    OP_DST <= 8'h01;
    OP_SRC <= 8'h02;
    @(posedge CLK);
    OP_VALID <= 0;
    #1;
    chk(DONE, 16'h0000);
    chk(FLAGS_OUT, e_fl);
    chk(PC_OUT, e_pc);
    rd(`CSB_REG_CTRL, 16'h0000);
    // Mid-run reset restores every output and the enable
    @(posedge CLK);
    RST <= 1;
    repeat (3) @(posedge CLK);
    RST <= 0;
    e_pc = `CSB_PC_RESET;
    e_fl = `CSB_FLAGS_RESET;
    e_cy = 2'h0;
    e_tk = 0;
    #1;
    chk(PC_OUT, e_pc);
    chk(FLAGS_OUT, e_fl);
    chk({BUSY, DONE, TAKEN}, 16'h0000);
    chk(RDATA, 16'h0000);
    rd(`CSB_REG_CTRL, `CSB_CTRL_RESET);
    rd(`CSB_REG_PC, e_pc);
    for (int i = 0; i < 500; i++) begin
      if (i % 16 == 0) begin
        rd(`CSB_REG_STATUS, {12'h000, e_cy, e_tk, 1'b0});
        r = $urandom;
        wr(`CSB_REG_FLAGS, r[15:0]);
        wr(`CSB_REG_PC, r[31:16]);
        e_fl = r[7:0];
        e_pc = r[31:16];
        rd(`CSB_REG_PC, e_pc);
      end
      r = $urandom;
      op(r[3:0], r[11:4], r[19:12], r[22:20], r[29:23], r[30]);
    end
    conclude;
  end
endmodule
bind csb_unit csb_monitor #(.PC_W(PC_W)) csb_monitor_inst (.CLK, .RST, .OP_VALID, .OP_CODE, .OP_OFFSET,
  .NEXT_TWO_WORD, .WR, .ADDR, .WDATA, .PC_OUT, .FLAGS_OUT, .BUSY, .DONE, .TAKEN);
